// >>> pkg/rtcsup_defs.svh
`ifndef RTCSUP_DEFS_SVH
`define RTCSUP_DEFS_SVH
// Register offsets
`define RTCSUP_OFS_HOURS 8'h03
`define RTCSUP_OFS_DAYREC 8'h04
`define RTCSUP_OFS_CALCTL 8'h08
`define RTCSUP_OFS_WDOG 8'h09
`define RTCSUP_OFS_ALMMON 8'h0A
`define RTCSUP_OFS_FLAGS 8'h0F
`define RTCSUP_OFS_SQWRATE 8'h13
// Field positions
`define RTCSUP_BIT_CENT_EN 7
`define RTCSUP_BIT_CENT_FLAG 6
`define RTCSUP_BIT_REC_SEL 7
`define RTCSUP_BIT_OUT_LVL 7
`define RTCSUP_BIT_FT_EN 6
`define RTCSUP_BIT_AFE 7
`define RTCSUP_BIT_ABE 5
`define RTCSUP_BIT_SQW_ENABLE 6
`define RTCSUP_BIT_WDS 7
`define RTCSUP_BIT_BL 4
`define RTCSUP_BIT_HT 6
// Oscillator tick: twice 32.768 kHz from 20 MHz, as a phase accumulator
`define RTCSUP_CLK_HZ 20000000
`define RTCSUP_OSC_HZ 32768
`define RTCSUP_PHASE_INC 25'd32768
`define RTCSUP_PHASE_MOD 25'd20000000
// Times in their own units
`define RTCSUP_REC_DEF_MS 97
`define RTCSUP_REC_HALT_MS 100
`define RTCSUP_REC_FAST_US 1000
`define RTCSUP_RESET_IN_N_MIN_NS 50
`define RTCSUP_BATT_PERIOD_H 24
// Cycle counts at 50 ns
`define RTCSUP_RESET_IN_N_CYC ((`RTCSUP_RESET_IN_N_MIN_NS + 49) / 50)
`define RTCSUP_REC_DEF_CYC (`RTCSUP_REC_DEF_MS * 20000)
`define RTCSUP_REC_HALT_CYC (`RTCSUP_REC_HALT_MS * 20000)
`define RTCSUP_REC_FAST_CYC (`RTCSUP_REC_FAST_US * 20)
`define RTCSUP_BATT_CYC (64'd`RTCSUP_BATT_PERIOD_H * 64'd3600 * 64'd20000000)
`endif

// >>> pkg/rtcsup_pkg.sv
package rtcsup_pkg;
  // Supervisor sequence, Gray coded along the power-up path
  typedef enum logic [1:0] {
    RTCSUP_OFF = 2'b00,
    RTCSUP_REC = 2'b01,
    RTCSUP_RUN = 2'b11
  } rtcsup_state_type;
  typedef logic [7:0] rtcsup_byte_type;
endpackage : rtcsup_pkg

// >>> rtl/rtcsup_glitch_filter.sv
`timescale 1ns/100ps
`include "rtcsup_defs.svh"
// Reports a low input only after it stays low for more than LEN cycles
module rtcsup_glitch_filter #(
  parameter int LEN = 1
) (
  // Clock and reset
  input wire logic clk_i,
  input wire logic reset_i,
  // Raw and filtered levels
  input wire logic level_n_i,
  output logic low_o
);
  logic [7:0] cnt; // Low run length
  logic [7:0] next_cnt;
  logic next_low;

  // Count consecutive low samples; any high restarts
  always_comb begin
    next_cnt = cnt;
    next_low = low_o;
    if (level_n_i) begin
      next_cnt = 8'h00;
      next_low = 1'b0;
    end else if (cnt < 8'(LEN)) begin
      next_cnt = cnt + 8'h01;
    end else begin
      next_low = 1'b1;
    end
  end

  // Register state
  always_ff @(posedge clk_i) begin
    if (reset_i) begin
      cnt <= 8'h00;
      low_o <= 1'b0;
    end else begin
      cnt <= next_cnt;
      low_o <= next_low;
    end
  end
endmodule : rtcsup_glitch_filter

// >>> rtl/rtcsup_sqw_gen.sv
`timescale 1ns/100ps
`include "rtcsup_defs.svh"
// Square wave from a half-period tick of 32.768 kHz by power-of-two division
module rtcsup_sqw_gen (
  // Clock and reset
  input wire logic clk_i,
  input wire logic reset_i,
  // Oscillator tick and control
  input wire logic osc_tick_i,
  input wire logic enable_i,
  input wire logic [3:0] rate_i,
  // Output
  output logic wave_o
);
  logic [15:0] div; // Ripple of oscillator half-periods
  logic [15:0] next_div;
  logic next_wave;

  // Divider bit k runs at 32768/2^k Hz; code 1 takes bit 0, codes 2..15 take bit code
  // Note the rate table skips 16.384 kHz, so code 2 already divides by four
  always_comb begin
    next_div = div;
    next_wave = 1'b0;
    if (osc_tick_i) begin
      next_div = div + 16'h0001;
    end
    if (enable_i && rate_i != 4'h0) begin
      if (rate_i == 4'h1) begin
        next_wave = div[0];
      end else begin
        next_wave = div[rate_i];
      end
    end
  end

  // Even duty: each divider bit is high for half its period
  always_ff @(posedge clk_i) begin
    if (reset_i) begin
      div <= 16'h0000;
      wave_o <= 1'b0;
    end else begin
      div <= next_div;
      wave_o <= next_wave;
    end
  end
endmodule : rtcsup_sqw_gen

// >>> rtl/rtcsup_core.sv
`timescale 1ns/100ps
`include "rtcsup_defs.svh"
// Behaviour
// - Rate code picks 32.768 kHz, then 8.192 kHz halving to 1 Hz
// - Square wave runs only while enable set
// - Reset low at trip, held for recovery
// - Reset input acts like power cycle
// - Reset released recovery time after input high
// - Power-fail output follows comparator when running
// - Back-up: comparator off, power-fail output low
// - Power return: power-fail high during recovery
// - Century flag toggles on rollover when enabled
// - Output pin follows level bit when idle
// - Battery checked at power-up and daily
// - Low flag holds until a passing check
// - No battery checks during back-up
// - Recovery length chosen by select and halt
// - Writes ignored until recovery ends
// - First power-up sets documented defaults
// - Later power-ups keep some bits, clear others
// - Steered watchdog timeout pulses reset
module rtcsup_core
  import rtcsup_pkg::*;
#(
  parameter int REC_DEF_CYC = `RTCSUP_REC_DEF_CYC,
  parameter int REC_HALT_CYC = `RTCSUP_REC_HALT_CYC,
  parameter longint BATT_CYC = `RTCSUP_BATT_CYC
) (
  // Clock and reset
  input wire logic clk_i,
  input wire logic reset_i,
  // Supply monitoring
  input wire logic vcc_ok_i,
  input wire logic battery_attach_i,
  input wire logic batt_below_i,
  input wire logic pfi_below_i,
  // External reset, watchdog and century rollover events
  input wire logic reset_in_n_i,
  input wire logic wdog_timeout_i,
  input wire logic century_rollover_i,
  // Register port
  input wire logic reg_wr_i,
  input wire logic [7:0] reg_addr_i,
  input wire logic [7:0] reg_wdata_i,
  output rtcsup_pkg::rtcsup_byte_type reg_rdata_o,
  output logic writes_blocked_o,
  // Pins, reset and irq open drain as output plus enable
  output logic reset_out_n_o,
  output logic reset_out_n_oe_o,
  output logic pwr_fail_out_n_o,
  output logic irq_test_out_pin_o,
  output logic irq_test_out_pin_oe_o,
  output logic square_wave_out_o
);
  import rtcsup_pkg::*;

  rtcsup_state_type state; // Supervisor sequence
  rtcsup_state_type next_state;
  logic [31:0] rec_cnt; // Recovery countdown
  logic [31:0] next_rec_cnt;
  logic [24:0] phase; // Oscillator phase accumulator, wide enough for the clock rate
  logic [24:0] next_phase;
  logic osc_tick;
  logic [63:0] batt_cnt; // Daily check timer
  logic [63:0] next_batt_cnt;
  logic reset_in_n_low; // Filtered reset input
  logic first_done; // A power-up has happened since reset
  logic next_first_done;
  logic was_run; // Last state run flag, never assigned or read
  // Register fields
  rtcsup_byte_type hours_century, next_hours_century;
  rtcsup_byte_type day_recovery_sel, next_day_recovery_sel;
  rtcsup_byte_type calibration_control, next_calibration_control;
  rtcsup_byte_type wdog_reg, next_wdog_reg;
  rtcsup_byte_type alarm_month_control, next_alarm_month_control;
  rtcsup_byte_type flags, next_flags;
  rtcsup_byte_type square_wave_rate, next_square_wave_rate;
  logic osc_halt, next_osc_halt; // Stop bit, normally in seconds register
  logic [31:0] rec_len; // Selected recovery length

  // Filter reset input; spikes under the floor never register
  rtcsup_glitch_filter #(
    .LEN(`RTCSUP_RESET_IN_N_CYC)
  ) u_filt (
    .clk_i(clk_i),
    .reset_i(reset_i),
    .level_n_i(reset_in_n_i),
    .low_o(reset_in_n_low)
  );

  // Square wave divider
  rtcsup_sqw_gen u_sqw (
    .clk_i(clk_i),
    .reset_i(reset_i),
    .osc_tick_i(osc_tick),
    .enable_i(alarm_month_control[`RTCSUP_BIT_SQW_ENABLE] && state == RTCSUP_RUN),
    .rate_i(square_wave_rate[3:0]),
    .wave_o(square_wave_out_o)
  );

  // Recovery length: fixed halfway values inside each window
  always_comb begin
    if (day_recovery_sel[`RTCSUP_BIT_REC_SEL]) begin
      rec_len = 32'(`RTCSUP_REC_FAST_CYC);
    end else if (osc_halt) begin
      rec_len = 32'(REC_HALT_CYC);
    end else begin
      rec_len = 32'(REC_DEF_CYC);
    end
  end

  // Oscillator tick at twice 32.768 kHz so the divider sees half-periods
  always_comb begin
    next_phase = phase + (`RTCSUP_PHASE_INC << 1);
    osc_tick = 1'b0;
    if (next_phase >= `RTCSUP_PHASE_MOD) begin
      next_phase = next_phase - `RTCSUP_PHASE_MOD;
      osc_tick = 1'b1;
    end
  end

  // Supervisor sequence: off, recovery, run
  always_comb begin
    next_state = state;
    next_rec_cnt = rec_cnt;
    case (state)
      RTCSUP_OFF: begin
        if (vcc_ok_i && !reset_in_n_low) begin
          next_state = RTCSUP_REC;
          next_rec_cnt = rec_len;
        end
      end
      RTCSUP_REC: begin
        if (!vcc_ok_i || reset_in_n_low) begin
          next_state = RTCSUP_OFF;
        end else if (rec_cnt <= 32'd1) begin
          next_state = RTCSUP_RUN;
        end else begin
          next_rec_cnt = rec_cnt - 32'd1;
        end
      end
      RTCSUP_RUN: begin
        if (!vcc_ok_i || reset_in_n_low) begin
          next_state = RTCSUP_OFF;
        end else if (wdog_timeout_i && wdog_reg[`RTCSUP_BIT_WDS]) begin
          next_state = RTCSUP_REC;
          next_rec_cnt = rec_len;
        end
      end
      default: begin
        next_state = RTCSUP_OFF;
      end
    endcase
  end

  // Registers, defaults and battery monitoring
  always_comb begin
    next_hours_century = hours_century;
    next_day_recovery_sel = day_recovery_sel;
    next_calibration_control = calibration_control;
    next_wdog_reg = wdog_reg;
    next_alarm_month_control = alarm_month_control;
    next_flags = flags;
    next_square_wave_rate = square_wave_rate;
    next_osc_halt = osc_halt;
    next_first_done = first_done;
    next_batt_cnt = batt_cnt;
    // Power-up defaults at recovery entry from off
    if (state == RTCSUP_OFF && next_state == RTCSUP_REC) begin
      if (!first_done || battery_attach_i) begin
        next_day_recovery_sel[`RTCSUP_BIT_REC_SEL] = 1'b0;
        next_osc_halt = 1'b1;
        next_calibration_control[`RTCSUP_BIT_OUT_LVL] = 1'b1;
      end // Else keep select, halt, level
      next_calibration_control[`RTCSUP_BIT_FT_EN] = 1'b0;
      next_alarm_month_control[`RTCSUP_BIT_AFE] = 1'b0;
      next_alarm_month_control[`RTCSUP_BIT_ABE] = 1'b0;
      next_alarm_month_control[`RTCSUP_BIT_SQW_ENABLE] = 1'b0;
      next_wdog_reg = 8'h00;
      next_flags[`RTCSUP_BIT_HT] = 1'b1;
      next_first_done = 1'b1;
      // Power-up battery check
      next_flags[`RTCSUP_BIT_BL] = batt_below_i;
      next_batt_cnt = 64'h0;
    end
    // Daily check only under main supply
    if (state != RTCSUP_OFF) begin
      if (batt_cnt >= 64'(BATT_CYC - 1)) begin
        next_batt_cnt = 64'h0;
        next_flags[`RTCSUP_BIT_BL] = batt_below_i;
      end else begin
        next_batt_cnt = batt_cnt + 64'h1;
      end
    end // Timer frozen in back-up
    // Steered watchdog clears its controls at timeout
    if (state == RTCSUP_RUN && wdog_timeout_i && wdog_reg[`RTCSUP_BIT_WDS]) begin
      next_wdog_reg = 8'h00;
      next_calibration_control[`RTCSUP_BIT_FT_EN] = 1'b0;
      next_alarm_month_control[`RTCSUP_BIT_AFE] = 1'b0;
      next_alarm_month_control[`RTCSUP_BIT_ABE] = 1'b0;
      next_alarm_month_control[`RTCSUP_BIT_SQW_ENABLE] = 1'b0;
    end
    // Software writes only once fully running
    if (reg_wr_i && state == RTCSUP_RUN) begin
      case (reg_addr_i)
        `RTCSUP_OFS_HOURS: next_hours_century = reg_wdata_i;
        `RTCSUP_OFS_DAYREC: next_day_recovery_sel = reg_wdata_i;
        `RTCSUP_OFS_CALCTL: next_calibration_control = reg_wdata_i;
        `RTCSUP_OFS_WDOG: next_wdog_reg = reg_wdata_i;
        `RTCSUP_OFS_ALMMON: next_alarm_month_control = reg_wdata_i;
        `RTCSUP_OFS_FLAGS: next_flags[`RTCSUP_BIT_HT] = reg_wdata_i[`RTCSUP_BIT_HT];
        `RTCSUP_OFS_SQWRATE: next_square_wave_rate = reg_wdata_i;
        default: next_flags = next_flags;
      endcase
    end
    // Rollover toggle wins over a same-cycle write
    if (century_rollover_i && hours_century[`RTCSUP_BIT_CENT_EN]) begin
      next_hours_century[`RTCSUP_BIT_CENT_FLAG] = ~hours_century[`RTCSUP_BIT_CENT_FLAG];
    end
  end

  // Read mux
  always_comb begin
    case (reg_addr_i)
      `RTCSUP_OFS_HOURS: reg_rdata_o = hours_century;
      `RTCSUP_OFS_DAYREC: reg_rdata_o = day_recovery_sel;
      `RTCSUP_OFS_CALCTL: reg_rdata_o = calibration_control;
      `RTCSUP_OFS_WDOG: reg_rdata_o = wdog_reg;
      `RTCSUP_OFS_ALMMON: reg_rdata_o = alarm_month_control;
      `RTCSUP_OFS_FLAGS: reg_rdata_o = flags;
      `RTCSUP_OFS_SQWRATE: reg_rdata_o = square_wave_rate;
      default: reg_rdata_o = 8'h00;
    endcase
  end

  // Pin outputs; open drain drives only low
  always_comb begin
    writes_blocked_o = (state != RTCSUP_RUN);
    reset_out_n_o = 1'b0;
    reset_out_n_oe_o = (state != RTCSUP_RUN);
    // Low in back-up, high in recovery, comparator when running
    case (state)
      RTCSUP_OFF: pwr_fail_out_n_o = 1'b0;
      RTCSUP_REC: pwr_fail_out_n_o = vcc_ok_i;
      RTCSUP_RUN: pwr_fail_out_n_o = !pfi_below_i;
      default: pwr_fail_out_n_o = 1'b0;
    endcase
    irq_test_out_pin_o = 1'b0;
    irq_test_out_pin_oe_o = 1'b0;
    // Plain output mode only with test, alarm irq and watchdog all idle
    if (!calibration_control[`RTCSUP_BIT_FT_EN] && !alarm_month_control[`RTCSUP_BIT_AFE]
        && wdog_reg == 8'h00) begin
      irq_test_out_pin_oe_o = !calibration_control[`RTCSUP_BIT_OUT_LVL];
    end
  end

  // Register all state
  always_ff @(posedge clk_i) begin
    if (reset_i) begin
      state <= RTCSUP_OFF;
      rec_cnt <= 32'd0;
      phase <= 25'h0000000;
      batt_cnt <= 64'h0;
      first_done <= 1'b0;
      hours_century <= 8'h00;
      day_recovery_sel <= 8'h00;
      calibration_control <= 8'h80;
      wdog_reg <= 8'h00;
      alarm_month_control <= 8'h00;
      flags <= 8'h40;
      square_wave_rate <= 8'h00;
      osc_halt <= 1'b1;
    end else begin
      state <= next_state;
      rec_cnt <= next_rec_cnt;
      phase <= next_phase;
      batt_cnt <= next_batt_cnt;
      first_done <= next_first_done;
      hours_century <= next_hours_century;
      day_recovery_sel <= next_day_recovery_sel;
      calibration_control <= next_calibration_control;
      wdog_reg <= next_wdog_reg;
      alarm_month_control <= next_alarm_month_control;
      flags <= next_flags;
      square_wave_rate <= next_square_wave_rate;
      osc_halt <= next_osc_halt;
    end
  end
endmodule : rtcsup_core

// >>> tb/rtcsup_core_props.sv
`timescale 1ns/100ps
module rtcsup_core_props
  import rtcsup_pkg::*;
(
  // Clock and reset
  input wire logic clk_i,
  input wire logic reset_i,
  // Core inputs
  input wire logic vcc_ok_i,
  input wire logic pfi_below_i,
  input wire logic reset_in_n_i,
  input wire logic century_rollover_i,
  input wire logic reg_wr_i,
  input wire logic [7:0] reg_addr_i,
  input wire logic [7:0] reg_wdata_i,
  // Core outputs
  input wire rtcsup_pkg::rtcsup_byte_type reg_rdata_o,
  input wire logic writes_blocked_o,
  input wire logic reset_out_n_o,
  input wire logic reset_out_n_oe_o,
  input wire logic pwr_fail_out_n_o,
  input wire logic irq_test_out_pin_oe_o,
  input wire logic square_wave_out_o
);
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (reset_i);
  // Rate register written, then read back
  sequence s_wr13;
    reg_wr_i && reg_addr_i == 8'h13 ##1 reg_addr_i == 8'h13;
  endsequence
  // Century turn seen while the hours byte is read
  sequence s_roll;
    century_rollover_i && !reg_wr_i && reg_addr_i == 8'h03 ##1 reg_addr_i == 8'h03;
  endsequence
  // Supply back with the reset input idle
  sequence s_return;
    $rose(vcc_ok_i) && reset_in_n_i ##1 writes_blocked_o && reset_in_n_i;
  endsequence
  // Rate code zero held long enough for the registered output
  sequence s_idle;
    (reg_addr_i == 8'h13 && reg_rdata_o[3:0] == 4'h0) [*3];
  endsequence
  chk_pfo_follow: assert property (
    !writes_blocked_o |-> pwr_fail_out_n_o == !pfi_below_i) else $error("pfo not following");
  chk_pfo_backup: assert property (
    !vcc_ok_i && writes_blocked_o |-> !pwr_fail_out_n_o) else $error("pfo high in backup");
  chk_pfo_return: assert property (
    s_return |-> pwr_fail_out_n_o) else $error("pfo low in recovery");
  chk_reset_trip: assert property (
    !vcc_ok_i |=> reset_out_n_oe_o) else $error("reset not pulled at trip");
  chk_reset_pin: assert property (
    reset_out_n_oe_o == writes_blocked_o && !reset_out_n_o) else $error("reset pin wrong");
  chk_write_taken: assert property (
    !writes_blocked_o ##0 s_wr13 |-> reg_rdata_o == $past(reg_wdata_i))
    else $error("write lost");
  chk_write_dropped: assert property (
    writes_blocked_o ##0 s_wr13 |-> reg_rdata_o == $past(reg_rdata_o))
    else $error("write in recovery");
  chk_century_flag: assert property (
    s_roll |-> reg_rdata_o[6] == ($past(reg_rdata_o[7]) ^ $past(reg_rdata_o[6])))
    else $error("century flag wrong");
  chk_out_level: assert property (
    reg_addr_i == 8'h08 && reg_rdata_o[7] |-> !irq_test_out_pin_oe_o)
    else $error("output pin low");
  chk_wave_idle: assert property (
    s_idle |-> !square_wave_out_o) else $error("wave without rate");
endmodule : rtcsup_core_props
bind rtcsup_core rtcsup_core_props u_props (
  .clk_i(clk_i),
  .reset_i(reset_i),
  .vcc_ok_i(vcc_ok_i),
  .pfi_below_i(pfi_below_i),
  .reset_in_n_i(reset_in_n_i),
  .century_rollover_i(century_rollover_i),
  .reg_wr_i(reg_wr_i),
  .reg_addr_i(reg_addr_i),
  .reg_wdata_i(reg_wdata_i),
  .reg_rdata_o(reg_rdata_o),
  .writes_blocked_o(writes_blocked_o),
  .reset_out_n_o(reset_out_n_o),
  .reset_out_n_oe_o(reset_out_n_oe_o),
  .pwr_fail_out_n_o(pwr_fail_out_n_o),
  .irq_test_out_pin_oe_o(irq_test_out_pin_oe_o),
  .square_wave_out_o(square_wave_out_o)
);

// >>> tb/rtcsup_host_model.sv
`timescale 1ns/100ps
module rtcsup_host_model (
  // Clock
  input wire logic clk_i,
  // Reset pin as pulled by the device
  input wire logic rst_oe_i,
  output logic rst_line_o,
  // Reset request towards the device
  output logic reset_in_n_o
);
  // Pull-up on the open-drain reset line
  assign rst_line_o = rst_oe_i ? 1'b0 : 1'b1;
  initial reset_in_n_o = 1'b1;
  // Whole-cycle low pulse, four cycles or more is 200 ns
  task automatic pulse(input int n);
    @(posedge clk_i);
    #5 reset_in_n_o = 1'b0;
    repeat (n) @(posedge clk_i);
    #5 reset_in_n_o = 1'b1;
  endtask : pulse
  // Glitch of 20 ns between edges, must be ignored
  task automatic glitch;
    @(posedge clk_i);
    #10 reset_in_n_o = 1'b0;
    #20 reset_in_n_o = 1'b1;
  endtask : glitch
endmodule : rtcsup_host_model

// >>> tb/rtc_supervisor_aux_outputs_bench.sv
`timescale 1ns/100ps
module rtc_supervisor_aux_outputs_bench;
  import rtcsup_pkg::*;
  // Stimulus
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic vcc = 1'b0;
  logic attach = 1'b1;
  logic bbelow = 1'b1;
  logic pfib = 1'b0;
  logic wdog = 1'b0;
  logic roll = 1'b0;
  logic wr_s = 1'b0;
  logic [7:0] addr = 8'h00;
  logic [7:0] wdata = 8'h00;
  // Observed
  rtcsup_byte_type rdata;
  logic blocked, rst_o, rst_oe, pwr_fail_out_n, irq_o, irq_oe, wave, reset_in_n_n, rst_line;
  int n_fail = 0;
  int total_checks = 0;
  // Short counts so recovery and battery checks fit the run
  localparam int LDEF = 20;
  localparam int LHALT = 30;
  always #25 clk = ~clk;
  rtcsup_core #(.REC_DEF_CYC(LDEF), .REC_HALT_CYC(LHALT), .BATT_CYC(500)) DUT (
    .clk_i(clk), .reset_i(rst), .vcc_ok_i(vcc), .battery_attach_i(attach),
    .batt_below_i(bbelow), .pfi_below_i(pfib), .reset_in_n_i(reset_in_n_n),
    .wdog_timeout_i(wdog), .century_rollover_i(roll), .reg_wr_i(wr_s),
    .reg_addr_i(addr), .reg_wdata_i(wdata), .reg_rdata_o(rdata),
    .writes_blocked_o(blocked), .reset_out_n_o(rst_o), .reset_out_n_oe_o(rst_oe),
    .pwr_fail_out_n_o(pwr_fail_out_n), .irq_test_out_pin_o(irq_o),
    .irq_test_out_pin_oe_o(irq_oe), .square_wave_out_o(wave));
  rtcsup_host_model host (.clk_i(clk), .rst_oe_i(rst_oe), .rst_line_o(rst_line),
    .reset_in_n_o(reset_in_n_n));
  // Verdict, single exit point
  task automatic summarize;
    $display("checks %0d mismatches %0d", total_checks, n_fail);
    if (n_fail == 0 && total_checks > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask : summarize
  task automatic check(input string nm, input logic [31:0] got, input logic [31:0] exp);
    total_checks++;
    if (got !== exp) begin
      n_fail++;
      $display("[ERR] %s exp %0h got %0h", nm, exp, got);
    end
  endtask : check
  // Inputs move 5 ns after the edge
  task automatic tick(input int n = 1);
    repeat (n) @(posedge clk);
    #5;
  endtask : tick
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    addr = a;
    wdata = d;
    wr_s = 1'b1;
    tick();
    wr_s = 1'b0;
    tick();
  endtask : wr
  task automatic rd(input logic [7:0] a, input logic [7:0] e);
    addr = a;
    #1 check($sformatf("reg %0h", a), rdata, e);
  endtask : rd
  // Bounded wait for writes to open, then judge the length
  task automatic run_wait(input int lo);
    int n;
    n = 0;
    while (blocked !== 1'b0) begin
      tick();
      n++;
      if (n > 21000) begin
        n_fail++;
        summarize();
      end
    end
    check("recovery", n >= lo && n <= lo + 4, 1);
  endtask : run_wait
  task automatic t_first_power;
    vcc = 1'b1;
    run_wait(LHALT);
    rd(8'h08, 8'h80);
    rd(8'h0A, 8'h00);
    rd(8'h04, 8'h00);
    rd(8'h09, 8'h00);
    rd(8'h0F, 8'h50);
    check("out oe", irq_oe, 0);
    wr(8'h20, 8'hAA);
    rd(8'h20, 8'h00);
    wr(8'h08, 8'h00);
    check("out oe", irq_oe, 1);
    check("out data", irq_o, 0);
    wr(8'h08, 8'h80);
    check("out oe", irq_oe, 0);
  endtask : t_first_power
  task automatic t_square;
    int c, n, hi;
    for (c = 4; c >= 2; c--) begin
      wr(8'h13, 8'(c));
      wr(8'h0A, 8'h40);
      for (int k = 0; k < 2; k++) begin
        n = 0;
        while (wave !== 1'b0 && n < 50000) begin tick(); n++; end
        while (wave !== 1'b1 && n < 50000) begin tick(); n++; end
      end
      // A stuck wave uses up the bound and ends the run
      if (n >= 50000) begin
        n_fail++;
        summarize();
      end
      check("sqw period", (n - (20000000 << c) / 32768) inside {[-650:650]}, 1);
    end
    wr(8'h0A, 8'h00);
    hi = 0;
    for (n = 0; n < 3000; n++) begin tick(); hi += (wave !== 1'b0); end
    check("sqw off", hi, 0);
    wr(8'h13, 8'h00);
  endtask : t_square
  task automatic t_century;
    wr(8'h03, 8'h80);
    roll = 1'b1;
    tick();
    roll = 1'b0;
    rd(8'h03, 8'hC0);
    wr(8'h03, 8'h40);
    roll = 1'b1;
    tick();
    roll = 1'b0;
    rd(8'h03, 8'h40);
  endtask : t_century
  task automatic t_reset_in;
    host.glitch();
    tick(3);
    check("glitch", blocked, 0);
    wr(8'h0A, 8'h40);
    host.pulse(4);
    check("rst line", rst_line, 0);
    run_wait(LHALT);
    rd(8'h0A, 8'h00);
    // Later power-ups: battery kept attached
    attach = 1'b0;
    wr(8'h0A, 8'h40);
    wr(8'h04, 8'h80);
    host.pulse(4);
    run_wait(20000);
    rd(8'h04, 8'h80);
    rd(8'h0A, 8'h00);
    wr(8'h04, 8'h00);
  endtask : t_reset_in
  task automatic t_supply;
    pfib = 1'b1;
    tick();
    check("pfo", pwr_fail_out_n, 0);
    pfib = 1'b0;
    vcc = 1'b0;
    tick(2);
    check("pfo", pwr_fail_out_n, 0);
    check("rst line", rst_line, 0);
    attach = 1'b0;
    bbelow = 1'b0;
    pfib = 1'b1;
    vcc = 1'b1;
    tick(2);
    check("pfo", pwr_fail_out_n, 1);
    wr(8'h13, 8'h0F);
    run_wait(LHALT - 4);
    rd(8'h13, 8'h00);
    check("pfo", pwr_fail_out_n, 0);
    rd(8'h0F, 8'h40);
    pfib = 1'b0;
    bbelow = 1'b1;
    tick(520);
    rd(8'h0F, 8'h50);
  endtask : t_supply
  task automatic t_watchdog;
    wr(8'h09, 8'h80);
    wdog = 1'b1;
    tick();
    wdog = 1'b0;
    tick();
    check("wdog reset", rst_line, 0);
    run_wait(LHALT - 2);
    rd(8'h09, 8'h00);
  endtask : t_watchdog
  initial begin
    tick(12);
    rst = 1'b0;
    tick();
    t_first_power();
    t_square();
    t_century();
    t_reset_in();
    t_supply();
    t_watchdog();
    summarize();
  end
endmodule : rtc_supervisor_aux_outputs_bench
